// [ppc_checker_sva.sv]
`timescale 1ns/1ps
module ppc_checker
	import ppc_pkg::*;
#(parameter int STEP_CYC = PPC_DRAIN_STEP_CYC) (
	// Inputs
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic dev_sleep,
	input wire logic port1_on_pin,
	input wire logic port1_overcurrent_flag,
	input wire logic thermal_shutdown,
	input wire logic port1_other_event,
	input wire logic port1_manual_drain,
	input wire logic port1_heavy_load_flag_exceeded,
	input wire logic port2_heavy_load_flag_exceeded,
	// Outputs
	input wire logic port1_alert,
	input wire logic port1_drain_on,
	input wire logic port1_on_state,
	input wire logic vtest_check_en,
	input wire logic bus_timeout_off,
	input wire logic heavy_load_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Length of the current drain pulse
	int run;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			run <= 0;
		else
			run <= port1_drain_on ? run + 1 : 0;
	end
	a_pin_state: assert property (port1_on_pin |-> port1_on_state)
		else $error("on state low with pin high");
	a_heavy_or: assert property (heavy_load_flag ==
		(port1_heavy_load_flag_exceeded || port2_heavy_load_flag_exceeded))
		else $error("heavy load flag wrong");
	a_alert_fault: assert property ((port1_overcurrent_flag ||
		thermal_shutdown) |=> port1_alert)
		else $error("alert missing on fault");
	a_alert_quiet: assert property (!(port1_overcurrent_flag ||
		thermal_shutdown || port1_other_event) |=> !port1_alert)
		else $error("alert without cause");
	a_manual_only: assert property ((!vtest_check_en &&
		!port1_manual_drain)[*3] |-> !port1_drain_on)
		else $error("drain with auto drain off");
	a_reset_vals: assert property ($fell(sys_rst) |-> bus_timeout_off &&
		!vtest_check_en && !port1_drain_on)
		else $error("bad value after reset");
	a_sleep_keep: assert property (dev_sleep && reg_wr |=>
		$stable(bus_timeout_off) && $stable(vtest_check_en))
		else $error("register changed in sleep");
	a_unmapped_wr: assert property (reg_wr && (reg_addr < 8'h11 ||
		reg_addr > 8'h13) |=> $stable(vtest_check_en))
		else $error("unmapped write took effect");
	// Bound allows two cycles of pipeline slack
	a_drain_len: assert property (run <= 4 * STEP_CYC + 2)
		else $error("drain pulse too long");
	c_drain: cover property ($rose(port1_drain_on));
	c_alert: cover property ($rose(port1_alert));
	c_sleep_wr: cover property (dev_sleep && reg_wr);
endmodule // ppc_checker

// [ppc_config_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - A set alert filter lets only overcurrent or thermal shutdown alert.
// - Forced drain, when active with auto drain on, opens switch and drains.
// - Forced drain bits are never cleared by hardware; the host clears them.
// - The software on bit ORed with the enable pin turns the switch on.
// - The shared duration field selects 100, 200, 300 or 400 ms of drain.
// - With auto drain off only manual bits drain; forced bits do nothing.
// - With auto drain on only forced bits and automatic requests drain; manual bits are ignored.
// - With auto drain off, the post-drain voltage check is skipped.
// - The pins bypass bit removes both enable pins from the power decision.
// - The timeout-off bit disables the bus timeout.
// - The heavy load flag is 1 when either port exceeds the heavy_load_flag level.
// - Register contents are held unchanged in Sleep.
// - Each port's on state tracks its pin ORed with its software on bit.
module ppc_config_regs
	import ppc_pkg::*;
#(
	parameter int STEP_CYC = PPC_DRAIN_STEP_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Device state
	input wire logic dev_active,
	input wire logic dev_sleep,
	// Port pins and events
	input wire logic port1_on_pin,
	input wire logic port2_on_pin,
	input wire logic port1_manual_drain,
	input wire logic port2_manual_drain,
	input wire logic port1_overcurrent_flag,
	input wire logic port2_overcurrent_flag,
	input wire logic thermal_shutdown,
	input wire logic port1_other_event,
	input wire logic port2_other_event,
	input wire logic port1_heavy_load_flag_exceeded,
	input wire logic port2_heavy_load_flag_exceeded,
	input wire logic port1_auto_drain_req,
	input wire logic port2_auto_drain_req,
	// Outputs to ports
	output logic port1_alert,
	output logic port2_alert,
	output logic port1_switch_on,
	output logic port2_switch_on,
	output logic port1_drain_on,
	output logic port2_drain_on,
	output logic port1_on_state,
	output logic port2_on_state,
	output logic vtest_check_en,
	output logic bus_timeout_off,
	output logic heavy_load_flag
);
	logic [7:0] port2_general_config;
	logic [7:0] port1_general_config;
	logic [7:0] global_general_config;
	logic port1_alert_filter;
	logic port2_alert_filter;
	logic port1_force_drain;
	logic port2_force_drain;
	logic port1_sw_on;
	logic port2_sw_on;
	logic [1:0] drain_duration;
	logic auto_drain_enable;
	logic enable_pins_bypass;
	logic wr_ok;
	logic [1:0] drain_req;
	logic [1:0] drain_act;

	// ------------------------------------------------------------------
	// Field views
	// ------------------------------------------------------------------
	assign port2_alert_filter = port2_general_config[PPC_BIT_ALERT_FILTER];
	assign port1_alert_filter = port1_general_config[PPC_BIT_ALERT_FILTER];
	assign port2_force_drain = port2_general_config[PPC_BIT_FORCE_DRAIN];
	assign port1_force_drain = port1_general_config[PPC_BIT_FORCE_DRAIN];
	assign port2_sw_on = port2_general_config[PPC_BIT_SW_ON];
	assign port1_sw_on = port1_general_config[PPC_BIT_SW_ON];
	assign drain_duration =
		port2_general_config[PPC_BIT_DUR_HI:PPC_BIT_DUR_LO];
	assign auto_drain_enable = port1_general_config[PPC_BIT_AUTO_DRAIN];
	assign enable_pins_bypass = global_general_config[PPC_BIT_PINS_BYPASS];

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	// hold in sleep
	assign wr_ok = reg_wr && !dev_sleep;

	// masked writes; no hardware clear of drain bits
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			port2_general_config <= PPC_RST_PORT2_CFG;
		else if (wr_ok && reg_addr == PPC_ADDR_PORT2_CFG)
			port2_general_config <=
				(reg_wdata & PPC_WMASK_PORT2_CFG) |
				(PPC_RST_PORT2_CFG & ~PPC_WMASK_PORT2_CFG);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			port1_general_config <= PPC_RST_PORT1_CFG;
		else if (wr_ok && reg_addr == PPC_ADDR_PORT1_CFG)
			port1_general_config <=
				(reg_wdata & PPC_WMASK_PORT1_CFG) |
				(PPC_RST_PORT1_CFG & ~PPC_WMASK_PORT1_CFG);
	end

	// Reserved bit left alone by hardware; host keeps it as is
	// reserved bit kept
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			global_general_config <= PPC_RST_GLOBAL_CFG;
		else if (wr_ok && reg_addr == PPC_ADDR_GLOBAL_CFG)
			global_general_config <=
				(reg_wdata & PPC_WMASK_GLOBAL_CFG) |
				(global_general_config & ~PPC_WMASK_GLOBAL_CFG);
	end

	// ------------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------------
	// heavy load flag, live OR
	assign heavy_load_flag = port1_heavy_load_flag_exceeded | port2_heavy_load_flag_exceeded;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				PPC_ADDR_PORT2_CFG: reg_rdata <= port2_general_config;
				PPC_ADDR_PORT1_CFG: reg_rdata <= port1_general_config;
				PPC_ADDR_GLOBAL_CFG: begin
					reg_rdata <= global_general_config;
					reg_rdata[PPC_BIT_HEAVY_LOAD] <= heavy_load_flag;
				end
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Alerts
	// ------------------------------------------------------------------
	// alert filter
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			port1_alert <= 1'b0;
			port2_alert <= 1'b0;
		end else begin
			port1_alert <= port1_overcurrent_flag | thermal_shutdown |
				(port1_other_event & ~port1_alert_filter);
			port2_alert <= port2_overcurrent_flag | thermal_shutdown |
				(port2_other_event & ~port2_alert_filter);
		end
	end

	// ------------------------------------------------------------------
	// Power enable
	// ------------------------------------------------------------------
	// on state is pin OR override
	assign port1_on_state = port1_on_pin | port1_sw_on;
	assign port2_on_state = port2_on_pin | port2_sw_on;

	// switch on; pins bypass; drain opens switch
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			port1_switch_on <= 1'b0;
			port2_switch_on <= 1'b0;
		end else begin
			port1_switch_on <= ((port1_on_pin & ~enable_pins_bypass) |
				port1_sw_on) & ~drain_act[0];
			port2_switch_on <= ((port2_on_pin & ~enable_pins_bypass) |
				port2_sw_on) & ~drain_act[1];
		end
	end

	// ------------------------------------------------------------------
	// Drain control
	// ------------------------------------------------------------------
	// manual only when auto off; forced only when auto on
	always_comb begin
		if (auto_drain_enable) begin
			drain_req[0] = (port1_force_drain & dev_active) |
				port1_auto_drain_req;
			drain_req[1] = (port2_force_drain & dev_active) |
				port2_auto_drain_req;
		end else begin
			drain_req[0] = port1_manual_drain;
			drain_req[1] = port2_manual_drain;
		end
	end

	// Manual drain follows the host bits directly, no timer
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_drain
			logic tmr_act;
			ppc_drain_timer #(
				.STEP_CYC(STEP_CYC)
			) u_timer (
				.clock(clock),
				.sys_rst(sys_rst),
				.start(drain_req[p] & auto_drain_enable),
				.duration(drain_duration),
				.active(tmr_act),
				.done()
			);
			assign drain_act[p] = auto_drain_enable ? tmr_act :
				drain_req[p];
		end
	endgenerate

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			port1_drain_on <= 1'b0;
			port2_drain_on <= 1'b0;
		end else begin
			port1_drain_on <= drain_act[0];
			port2_drain_on <= drain_act[1];
		end
	end

	// voltage check only with auto drain
	assign vtest_check_en = auto_drain_enable;
	assign bus_timeout_off = global_general_config[PPC_BIT_TIMEOUT_OFF];
endmodule // ppc_config_regs

// [ppc_drain_timer.sv]
`timescale 1ns/1ps
module ppc_drain_timer
	import ppc_pkg::*;
#(
	parameter int STEP_CYC = PPC_DRAIN_STEP_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	input wire logic [1:0] duration,
	// Status
	output logic active,
	output logic done
);
	ppc_drain_e state;
	logic [31:0] cyc;
	logic [2:0] steps;

	// ------------------------------------------------------------------
	// Duration count: (code+1) steps of 100 ms
	// ------------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= PPC_DR_IDLE;
			cyc <= 32'h0;
			steps <= 3'h0;
		end else begin
			unique case (state)
				PPC_DR_IDLE: begin
					if (start) begin
						state <= PPC_DR_RUN;
						cyc <= 32'h0;
						steps <= 3'({1'b0, duration} + 3'h1);
					end
				end
				PPC_DR_RUN: begin
					if (cyc == 32'(STEP_CYC - 1)) begin
						cyc <= 32'h0;
						steps <= steps - 3'h1;
						if (steps == 3'h1)
							state <= PPC_DR_DONE;
					end else begin
						cyc <= cyc + 32'h1;
					end
				end
				// Hold until the request drops, so one request drains once
				PPC_DR_DONE: begin
					if (!start)
						state <= PPC_DR_IDLE;
				end
				default: state <= PPC_DR_IDLE;
			endcase
		end
	end

	assign active = (state == PPC_DR_RUN);
	assign done = (state == PPC_DR_DONE);
endmodule // ppc_drain_timer

// [ppc_host.sv]
`timescale 1ns/1ps
module ppc_host
	import ppc_pkg::*;
(
	// Bus
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= (a == PPC_ADDR_GLOBAL_CFG) ? (d | 8'h40) : d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule // ppc_host

// [ppc_pkg.sv]
package ppc_pkg;
	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] PPC_ADDR_PORT2_CFG = 8'h11;
	localparam logic [7:0] PPC_ADDR_PORT1_CFG = 8'h12;
	localparam logic [7:0] PPC_ADDR_GLOBAL_CFG = 8'h13;
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int PPC_BIT_ALERT_FILTER = 7;
	localparam int PPC_BIT_FORCE_DRAIN = 5;
	localparam int PPC_BIT_SW_ON = 4;
	localparam int PPC_BIT_DUR_HI = 3;
	localparam int PPC_BIT_DUR_LO = 2;
	localparam int PPC_BIT_AUTO_DRAIN = 2;
	localparam int PPC_BIT_PINS_BYPASS = 7;
	localparam int PPC_BIT_RESERVED = 6;
	localparam int PPC_BIT_TIMEOUT_OFF = 5;
	localparam int PPC_BIT_HEAVY_LOAD = 2;
	// ------------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------------
	localparam logic [7:0] PPC_RST_PORT2_CFG = 8'h06;
	localparam logic [7:0] PPC_RST_PORT1_CFG = 8'h02;
	localparam logic [7:0] PPC_RST_GLOBAL_CFG = 8'h60;
	localparam logic [7:0] PPC_WMASK_PORT2_CFG = 8'hbc;
	localparam logic [7:0] PPC_WMASK_PORT1_CFG = 8'hb4;
	localparam logic [7:0] PPC_WMASK_GLOBAL_CFG = 8'ha0;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int PPC_CLK_HZ = 40000000;
	localparam int PPC_DRAIN_STEP_MS = 100;
	localparam int PPC_DRAIN_STEP_CYC = PPC_CLK_HZ / 1000 * PPC_DRAIN_STEP_MS;
	localparam int PPC_MAX_STEPS = 4;
	typedef enum logic [1:0] {
		PPC_DR_IDLE,
		PPC_DR_RUN,
		PPC_DR_DONE
	} ppc_drain_e;
endpackage

// [testbench.sv]
`timescale 1ns/1ps
module testbench
	import ppc_pkg::*;
;
	localparam int STEP_CYC = 10;
	localparam logic [7:0] A1 = PPC_ADDR_PORT1_CFG;
	localparam logic [7:0] AG = PPC_ADDR_GLOBAL_CFG;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic dev_active = 1'b1, dev_sleep = 1'b0;
	logic port1_on_pin = 1'b0, port2_on_pin = 1'b0;
	logic port1_manual_drain = 1'b0, port2_manual_drain = 1'b0;
	logic port1_overcurrent_flag = 1'b0, port2_overcurrent_flag = 1'b0;
	logic thermal_shutdown = 1'b0;
	logic port1_other_event = 1'b0, port2_other_event = 1'b0;
	logic port1_heavy_load_flag_exceeded = 1'b0, port2_heavy_load_flag_exceeded = 1'b0;
	logic port1_auto_drain_req = 1'b0, port2_auto_drain_req = 1'b0;
	wire reg_wr, reg_rd;
	wire [7:0] reg_addr, reg_wdata;
	logic [7:0] reg_rdata;
	logic port1_alert, port2_alert, port1_switch_on, port2_switch_on;
	logic port1_drain_on, port2_drain_on, port1_on_state, port2_on_state;
	logic vtest_check_en, bus_timeout_off, heavy_load_flag;
	int errors = 0, checked = 0;
	ppc_config_regs #(.STEP_CYC(STEP_CYC)) dut (.*);
	ppc_host host (.*);
	always #12.5 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic conclude();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_regs();
		logic [7:0] a [3] = '{PPC_ADDR_PORT2_CFG, PPC_ADDR_PORT1_CFG,
			PPC_ADDR_GLOBAL_CFG};
		logic [7:0] r [3] = '{PPC_RST_PORT2_CFG, PPC_RST_PORT1_CFG,
			PPC_RST_GLOBAL_CFG};
		logic [7:0] m [3] = '{PPC_WMASK_PORT2_CFG, PPC_WMASK_PORT1_CFG,
			PPC_WMASK_GLOBAL_CFG};
		logic [7:0] d;
		for (int i = 0; i < 3; i++) begin
			host.rd(a[i], d);
			chk(d, r[i]);
			host.wr(a[i], 8'hff);
			host.rd(a[i], d);
			chk(d, m[i] | (r[i] & ~m[i]));
			// Reset value is 1, and the all-ones write keeps it 1
			chk(8'(bus_timeout_off), 8'h1);
			host.wr(a[i], 8'h00);
			host.rd(a[i], d);
			chk(d, r[i] & ~m[i]);
			chk(8'(bus_timeout_off), 8'(i != 2));
		end
		host.wr(8'h14, 8'hff);
		host.rd(8'h14, d);
		chk(d, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_pins();
		host.wr(A1, 8'h10);
		wt(3);
		chk(8'({port1_on_state, port1_switch_on, port2_switch_on}), 8'h6);
		@(posedge clock);
		port2_on_pin <= 1'b1;
		wt(3);
		chk(8'({port2_on_state, port2_switch_on}), 8'h3);
		// Software override still wins
		host.wr(AG, 8'h80);
		wt(3);
		chk(8'({port2_on_state, port2_switch_on, port1_switch_on}), 8'h5);
		host.wr(AG, 8'h00);
		host.wr(A1, 8'h00);
		port2_on_pin <= 1'b0;
		$display("test pins done");
	endtask
	task automatic t_alert();
		logic [7:0] d;
		host.wr(A1, 8'h80);
		@(posedge clock);
		port1_other_event <= 1'b1;
		port2_other_event <= 1'b1;
		port1_heavy_load_flag_exceeded <= 1'b1;
		wt(3);
		chk(8'({port1_alert, port2_alert, heavy_load_flag}), 8'h3);
		host.rd(AG, d);
		chk(d, 8'h44);
		@(posedge clock);
		thermal_shutdown <= 1'b1;
		wt(3);
		chk(8'({port1_alert, port2_alert}), 8'h3);
		// Overcurrent passes the filter and stays on its own port
		@(posedge clock);
		thermal_shutdown <= 1'b0;
		port1_overcurrent_flag <= 1'b1;
		port2_other_event <= 1'b0;
		wt(3);
		chk(8'({port1_alert, port2_alert}), 8'h2);
		@(posedge clock);
		port1_overcurrent_flag <= 1'b0;
		port2_overcurrent_flag <= 1'b1;
		wt(3);
		chk(8'({port1_alert, port2_alert}), 8'h1);
		@(posedge clock);
		port2_overcurrent_flag <= 1'b0;
		port1_heavy_load_flag_exceeded <= 1'b0;
		host.wr(A1, 8'h00);
		wt(3);
		chk(8'(port1_alert), 8'h1);
		@(posedge clock);
		port1_other_event <= 1'b0;
		$display("test alert done");
	endtask
	task automatic t_drain();
		logic [7:0] d;
		int n = 0;
		host.wr(PPC_ADDR_PORT2_CFG, 8'h0c);
		host.wr(A1, 8'h14);
		port1_manual_drain <= 1'b1;
		wt(4);
		chk(8'({vtest_check_en, port1_drain_on}), 8'h2);
		host.wr(A1, 8'h34);
		for (int k = 0; k < 100; k++) begin
			wt(1);
			if (port1_drain_on === 1'b1)
				n++;
			if (n == 5)
				chk(8'(port1_switch_on), 8'h0);
		end
		chk(8'(n), 8'(4 * STEP_CYC));
		host.rd(A1, d);
		chk(d, 8'h36);
		// Automatic request drains while auto drain is on
		@(posedge clock);
		port2_auto_drain_req <= 1'b1;
		wt(3);
		chk(8'({port2_drain_on, port2_switch_on}), 8'h2);
		@(posedge clock);
		port2_auto_drain_req <= 1'b0;
		host.wr(A1, 8'h10);
		wt(3);
		chk(8'({vtest_check_en, port1_drain_on}), 8'h1);
		@(posedge clock);
		port1_manual_drain <= 1'b0;
		host.wr(A1, 8'h30);
		wt(5);
		chk(8'(port1_drain_on), 8'h0);
		host.wr(A1, 8'h00);
		// Forced drain needs the Active state
		dev_active <= 1'b0;
		host.wr(A1, 8'h34);
		wt(4);
		chk(8'({port1_drain_on, port1_switch_on}), 8'h1);
		host.wr(A1, 8'h00);
		@(posedge clock);
		dev_active <= 1'b1;
		$display("test drain done");
	endtask
	task automatic t_sleep();
		logic [7:0] d;
		host.wr(AG, 8'h20);
		dev_sleep <= 1'b1;
		host.wr(AG, 8'h00);
		host.rd(AG, d);
		chk(d, 8'h60);
		dev_sleep <= 1'b0;
		host.wr(AG, 8'h00);
		wt(2);
		chk(8'(bus_timeout_off), 8'h0);
		$display("test sleep done");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs();
		t_pins();
		t_alert();
		t_drain();
		t_sleep();
		conclude();
	end
	// Whole run is far below this span
	initial begin
		#100us;
		errors++;
		conclude();
	end
endmodule // testbench
bind ppc_config_regs ppc_checker #(.STEP_CYC(STEP_CYC)) u_chk (.*);
